// File: design/ipf_params.svh
`ifndef IPF_PARAMS_SVH
`define IPF_PARAMS_SVH
// segment framing
`define IPF_SEG_LAST 4'hf
`define IPF_SEG_ZERO 4'h0
`define IPF_REC_EDGES 6'd17
`define IPF_EDGE_MAX 6'h3f
// read budget per data-ready interval, per unit of decimation factor
`define IPF_READS_BASE 20'd12
`define IPF_READS_MAX 20'hfffff
// output word alignment
`define IPF_WORD_BITS 6'd16
`define IPF_FILT_STAGES 2
// register addresses (seven-bit, taken from command bits [14:8])
`define IPF_ADDR_DIAG 7'h02
`define IPF_ADDR_GX_LO 7'h04
`define IPF_ADDR_GX_HI 7'h06
`define IPF_ADDR_GY_LO 7'h08
`define IPF_ADDR_GY_HI 7'h0a
`define IPF_ADDR_GZ_LO 7'h0c
`define IPF_ADDR_GZ_HI 7'h0e
`define IPF_ADDR_AX_HI 7'h12
`define IPF_ADDR_AY_HI 7'h16
`define IPF_ADDR_AZ_HI 7'h1a
`define IPF_ADDR_PROD 7'h72
// product code: arbitrary neutral value
`define IPF_PROD_CODE 16'h1a2b
// diagnostic status bit positions
`define IPF_DIAG_LOCK_BIT 0
`define IPF_DIAG_DESYNC_BIT 1
`define IPF_DIAG_OVR_BIT 7
// response buffer
`define IPF_FIFO_FULL 2'd2
`endif

// File: design/ipf_pkg.sv
`default_nettype none
package ipf_pkg;
    typedef enum logic [1:0] {ST_OK, ST_DESYNC, ST_LOCKED} ipf_state_t;
    typedef struct packed {
        logic [2:0][31:0] gyro;
        logic [2:0][15:0] accel;
    } ipf_sample_t;
    typedef struct packed {
        logic [15:0] dec;
        logic [2:0] filt;
    } ipf_cfg_t;
endpackage
`default_nettype wire

// File: design/ipf_spi_port.sv
`timescale 1ns/1ns
`default_nettype none
`include "ipf_params.svh"
module ipf_spi_port (
    // system
    input wire logic clk,
    input wire logic sys_rst,
    // serial pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    output logic dout,
    output logic dout_oe,
    output logic data_ready,
    // sensor chain
    input wire logic sample_valid,
    input wire ipf_pkg::ipf_sample_t sample,
    // configuration
    input wire ipf_pkg::ipf_cfg_t cfg,
    // status
    output logic [15:0] diagnostic_status,
    output ipf_pkg::ipf_state_t port_state
);
    import ipf_pkg::*;

    function automatic logic [4:0] ipf_clog2(input logic [16:0] v);
        logic [4:0] r;
        r = 5'h0;
        for (int i = 0; i < 17; i++) begin
            if ((17'h1 << i) < v) begin
                r = 5'(i + 1);
            end
        end
        return r;
    endfunction

    // pin synchronisers: stage 0 feeds only stage 1, stage 2 is the previous value
    logic [2:0] sclk_sr_q, cs_sr_q, din_sr_q;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sclk_sr_q <= 3'h7;
            cs_sr_q <= 3'h7;
            din_sr_q <= 3'h0;
        end else begin
            sclk_sr_q <= {sclk_sr_q[1:0], sclk};
            cs_sr_q <= {cs_sr_q[1:0], cs_n};
            din_sr_q <= {din_sr_q[1:0], din};
        end
    end
    logic cs_low, cs_fall, cs_rise, rise_act, fall_act;
    assign cs_low = ~cs_sr_q[1];
    assign cs_fall = ~cs_sr_q[1] & cs_sr_q[2];
    assign cs_rise = cs_sr_q[1] & ~cs_sr_q[2];
    assign rise_act = sclk_sr_q[1] & ~sclk_sr_q[2] & cs_low;
    assign fall_act = ~sclk_sr_q[1] & sclk_sr_q[2] & cs_low;

    // segment counting
    logic [3:0] bit_cnt_q;
    logic mid_q, seg_any_q;
    logic [5:0] edges_q;
    logic [15:0] rx_q;
    logic [15:0] rx_word;
    logic seg_end;
    assign rx_word = {rx_q[14:0], din_sr_q[1]};
    assign seg_end = rise_act && bit_cnt_q == `IPF_SEG_LAST;
    always_ff @(posedge clk) begin
        if (sys_rst || cs_fall) begin
            bit_cnt_q <= `IPF_SEG_ZERO;
            mid_q <= 1'b0;
            seg_any_q <= 1'b0;
            edges_q <= 6'h0;
        end else if (rise_act) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
            mid_q <= 1'b1;
            if (edges_q != `IPF_EDGE_MAX) begin
                edges_q <= edges_q + 6'h1;
            end
            if (seg_end) begin
                seg_any_q <= 1'b1;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rx_q <= 16'h0;
        end else if (rise_act) begin
            rx_q <= rx_word;
        end
    end

    // port framing state
    ipf_state_t state_q;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= ST_OK;
        end else if (cs_rise) begin
            unique case (state_q)
                ST_OK: begin
                    if (bit_cnt_q != `IPF_SEG_ZERO) begin
                        state_q <= seg_any_q ? ST_DESYNC : ST_LOCKED;
                    end
                end
                ST_DESYNC: begin
                    if (edges_q == `IPF_REC_EDGES) begin
                        state_q <= ST_OK;
                    end
                end
                ST_LOCKED: state_q <= ST_LOCKED;
            endcase
        end
    end
    assign port_state = state_q;

    // decimation and output alignment
    logic [15:0] dec_cnt_q;
    logic dec_end, data_ready_q;
    logic [5:0] growth;
    logic [4:0] shift_amt;
    logic [2:0][31:0] gyro_acc_q, gyro_out_q;
    logic [2:0][15:0] accel_q;
    assign dec_end = sample_valid && dec_cnt_q >= cfg.dec;
    assign growth = {1'b0, ipf_clog2({1'b0, cfg.dec} + 17'h1)}
                    + 6'(cfg.filt * `IPF_FILT_STAGES);
    assign shift_amt = (growth >= `IPF_WORD_BITS) ? 5'h0
                       : 5'(`IPF_WORD_BITS - growth);
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dec_cnt_q <= 16'h0;
            data_ready_q <= 1'b0;
        end else begin
            data_ready_q <= dec_end;
            if (sample_valid) begin
                dec_cnt_q <= dec_end ? 16'h0 : dec_cnt_q + 16'h1;
            end
        end
    end
    assign data_ready = data_ready_q;
    for (genvar g = 0; g < 3; g++) begin : g_axis
        logic [31:0] sum;
        assign sum = gyro_acc_q[g] + sample.gyro[g];
        always_ff @(posedge clk) begin
            if (sys_rst) begin
                gyro_acc_q[g] <= 32'h0;
                gyro_out_q[g] <= 32'h0;
                accel_q[g] <= 16'h0;
            end else if (dec_end) begin
                gyro_acc_q[g] <= 32'h0;
                gyro_out_q[g] <= sum << shift_amt;
                accel_q[g] <= sample.accel[g];
            end else if (sample_valid) begin
                gyro_acc_q[g] <= sum;
            end
        end
    end

    // register reads
    logic cmd_read, diag_take;
    logic [6:0] cmd_addr;
    logic [15:0] rd_data;
    logic ovr_q;
    assign cmd_addr = rx_word[14:8];
    assign cmd_read = seg_end && state_q == ST_OK && !rx_word[15];
    assign diag_take = cmd_read && cmd_addr == `IPF_ADDR_DIAG;
    always_comb begin
        diagnostic_status = 16'h0;
        diagnostic_status[`IPF_DIAG_OVR_BIT] = ovr_q;
        diagnostic_status[`IPF_DIAG_DESYNC_BIT] = state_q == ST_DESYNC;
        diagnostic_status[`IPF_DIAG_LOCK_BIT] = state_q == ST_LOCKED;
    end
    always_comb begin
        case (cmd_addr)
            `IPF_ADDR_DIAG: rd_data = diagnostic_status;
            `IPF_ADDR_GX_LO: rd_data = gyro_out_q[0][15:0];
            `IPF_ADDR_GX_HI: rd_data = gyro_out_q[0][31:16];
            `IPF_ADDR_GY_LO: rd_data = gyro_out_q[1][15:0];
            `IPF_ADDR_GY_HI: rd_data = gyro_out_q[1][31:16];
            `IPF_ADDR_GZ_LO: rd_data = gyro_out_q[2][15:0];
            `IPF_ADDR_GZ_HI: rd_data = gyro_out_q[2][31:16];
            `IPF_ADDR_AX_HI: rd_data = accel_q[0];
            `IPF_ADDR_AY_HI: rd_data = accel_q[1];
            `IPF_ADDR_AZ_HI: rd_data = accel_q[2];
            `IPF_ADDR_PROD: rd_data = `IPF_PROD_CODE;
            default: rd_data = 16'h0;
        endcase
    end

    // read budget per data-ready interval
    logic [19:0] budget, reads_q;
    logic ovr_set;
    assign budget = ({4'h0, cfg.dec} + 20'h1) * `IPF_READS_BASE;
    assign ovr_set = cmd_read && !data_ready_q && reads_q >= budget;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reads_q <= 20'h0;
        end else if (data_ready_q) begin
            reads_q <= {19'h0, cmd_read};
        end else if (cmd_read && reads_q != `IPF_READS_MAX) begin
            reads_q <= reads_q + 20'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ovr_q <= 1'b0;
        end else if (ovr_set) begin
            ovr_q <= 1'b1;
        end else if (diag_take) begin
            ovr_q <= 1'b0;
        end
    end

    // pending answer and two-entry response buffer
    logic pend_q;
    logic [15:0] pend_word_q;
    logic [15:0] fifo_mem_q [2];
    logic wr_ptr_q, rd_ptr_q;
    logic [1:0] fifo_cnt_q;
    logic fifo_in_ready, fifo_out_valid, push, pop, load_evt, shift_evt;
    assign fifo_in_ready = fifo_cnt_q != `IPF_FIFO_FULL;
    assign fifo_out_valid = fifo_cnt_q != 2'h0;
    assign push = pend_q && fifo_in_ready;
    assign load_evt = cs_fall | (fall_act & mid_q & bit_cnt_q == `IPF_SEG_ZERO);
    assign shift_evt = fall_act & mid_q & bit_cnt_q != `IPF_SEG_ZERO;
    assign pop = load_evt && fifo_out_valid && state_q == ST_OK;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pend_q <= 1'b0;
            pend_word_q <= 16'h0;
        end else if (cmd_read) begin
            pend_q <= 1'b1;
            pend_word_q <= rd_data;
        end else if (fifo_in_ready) begin
            pend_q <= 1'b0;
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst || state_q != ST_OK) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
            fifo_cnt_q <= 2'h0;
        end else begin
            if (push) begin
                fifo_mem_q[wr_ptr_q] <= pend_word_q;
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (pop) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
            fifo_cnt_q <= fifo_cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    // serial output, mode 3: change after falling edges
    logic [15:0] tx_q;
    logic oe_q;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_q <= 16'h0;
            oe_q <= 1'b0;
        end else begin
            oe_q <= cs_low;
            if (load_evt) begin
                tx_q <= pop ? fifo_mem_q[rd_ptr_q] : 16'h0;
            end else if (shift_evt) begin
                tx_q <= {tx_q[14:0], 1'b0};
            end
        end
    end
    assign dout = tx_q[15];
    assign dout_oe = oe_q;

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_short_frame;
        cs_rise && state_q == ST_OK && bit_cnt_q != `IPF_SEG_ZERO && !seg_any_q;
    endsequence
    sequence s_recovery_frame;
        cs_rise && state_q == ST_DESYNC && edges_q == `IPF_REC_EDGES;
    endsequence
    chk_overrun_set: assert property (ovr_set |=> ovr_q && diagnostic_status[`IPF_DIAG_OVR_BIT])
        else $error("overrun not flagged");
    chk_budget_ok: assert property ($rose(ovr_q) |-> $past(cmd_read && reads_q >= budget))
        else $error("overrun flagged within budget");
    chk_budget_scale: assert property (budget == 20'(({4'h0, cfg.dec} + 20'h1) * 20'd12))
        else $error("read budget wrong");
    chk_overrun_hold: assert property (ovr_q && !diag_take |=> ovr_q)
        else $error("overrun dropped without read");
    chk_segment_answer: assert property (cmd_read |=> pend_q ##[0:2] !pend_q)
        else $error("answer not queued");
    chk_lock_enter: assert property (s_short_frame |=> state_q == ST_LOCKED [*8])
        else $error("short frame did not lock");
    chk_resync_frame: assert property (s_recovery_frame |=> state_q == ST_OK)
        else $error("recovery frame ignored");
    chk_dec_ready: assert property (dec_end |=> data_ready && dec_cnt_q == 16'h0)
        else $error("decimation end missed");
    chk_plain_width: assert property (cfg.dec == 16'h0 && cfg.filt == 3'h0 |-> shift_amt == 5'd16)
        else $error("unfiltered data not in upper word");
    chk_growth_bits: assert property (cfg.dec == 16'h7 && cfg.filt == 3'h2 |-> growth == 6'd7)
        else $error("bit growth wrong");
    chk_lower_word: assert property (dec_end |=> gyro_out_q[0] == $past(g_axis[0].sum << shift_amt))
        else $error("lower word not extended");
    chk_prod_code: assert property (cmd_read && cmd_addr == `IPF_ADDR_PROD |=> pend_word_q == `IPF_PROD_CODE)
        else $error("product code wrong");
endmodule
`default_nettype wire

// File: verification/ipf_host_model.sv
`timescale 1ns/1ns
`default_nettype none
`include "ipf_params.svh"
module ipf_host_model (
    // serial pins
    output logic sclk,
    output logic cs_n,
    output logic din,
    input wire logic dout,
    input wire logic dout_oe
);
    logic [15:0] txw [0:39];
    logic [15:0] rxw [0:39];
    logic b;

    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din = 1'b0;
        b = 1'b0;
    end

    // mode 3 frame at a 125 ns sclk; no stall between segments, sclk still outside frames
    task automatic frame(input int nedges);
        int i;
        cs_n = 1'b0;
        #62;
        for (i = 0; i < nedges; i++) begin
            sclk = 1'b0;
            din = txw[i / 16][15 - i % 16];
            #62;
            sclk = 1'b1;
            // a released dout shows the inverse of the last bit, never a stale copy
            b = dout_oe ? dout : ~b;
            rxw[i / 16][15 - i % 16] = b;
            #63;
        end
        cs_n = 1'b1;
        din = ~din;
        #100;
    endtask

    // seventeen-edge frame then a check read of the product code, at most fifteen times
    task automatic recover(input logic [15:0] code, output int tries);
        tries = 0;
        do begin
            frame(17);
            txw[0] = {1'b0, `IPF_ADDR_PROD, 8'h00};
            txw[1] = 16'h8000;
            frame(32);
            tries++;
        end while (rxw[1] !== code && tries < 15);
    endtask
endmodule
`default_nettype wire

// File: verification/ipf_spi_port_test.sv
`timescale 1ns/1ns
`default_nettype none
`include "ipf_params.svh"
module ipf_spi_port_test;
    import ipf_pkg::*;
    localparam logic [15:0] CMD_PROD = {1'b0, `IPF_ADDR_PROD, 8'h00};
    logic clk;
    logic sys_rst;
    wire logic sclk;
    wire logic cs_n;
    wire logic din;
    logic dout, dout_oe, data_ready, sample_valid;
    ipf_sample_t sample;
    ipf_cfg_t cfg;
    logic [15:0] diagnostic_status;
    ipf_state_t port_state;
    int n_fail, compares, cycles;

    ipf_spi_port dut (.clk(clk), .sys_rst(sys_rst), .sclk(sclk), .cs_n(cs_n), .din(din),
        .dout(dout), .dout_oe(dout_oe), .data_ready(data_ready), .sample_valid(sample_valid),
        .sample(sample), .cfg(cfg), .diagnostic_status(diagnostic_status),
        .port_state(port_state));
    ipf_host_model host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_fail++;
            report_and_stop();
        end
    end

    // n sample strobes, axis j carries v + j, then wait for the output strobe
    task automatic pulse_samples(input int n, input logic [31:0] v);
        int i;
        int j;
        int w;
        for (i = 0; i < n; i++) begin
            @(posedge clk);
            for (j = 0; j < 3; j++) begin
                sample.gyro[j] <= v + 32'(j);
                sample.accel[j] <= 16'h0a00 + 16'(i);
            end
            sample_valid <= 1'b1;
            @(posedge clk);
            sample_valid <= 1'b0;
        end
        w = 0;
        // let the edge's updates settle before looking at the one-cycle strobe
        #1;
        while (data_ready !== 1'b1 && w < 6) begin
            @(posedge clk);
            #1;
            w++;
        end
        check("data_ready", data_ready, 1'b1);
    endtask

    // frame of n queued commands plus one ignored write word that collects the last answer
    task automatic rd(input int n);
        host.txw[n] = 16'h8000;
        host.frame(16 * (n + 1));
    endtask

    task automatic budget(input logic [15:0] dec);
        int i;
        int lim;
        lim = 12 * (dec + 1);
        @(posedge clk);
        cfg.dec <= dec;
        pulse_samples(dec + 1, 32'h1);
        for (i = 0; i < lim; i++) host.txw[i] = CMD_PROD;
        rd(lim);
        for (i = 1; i <= lim; i++) check("product code", host.rxw[i], `IPF_PROD_CODE);
        check("overrun within budget", diagnostic_status[`IPF_DIAG_OVR_BIT], 1'b0);
        host.txw[0] = CMD_PROD;
        rd(1);
        check("overrun past budget", diagnostic_status[`IPF_DIAG_OVR_BIT], 1'b1);
        pulse_samples(dec + 1, 32'h1);
        check("overrun kept", diagnostic_status[`IPF_DIAG_OVR_BIT], 1'b1);
        host.txw[0] = {1'b0, `IPF_ADDR_DIAG, 8'h00};
        rd(1);
        check("status word overrun", host.rxw[1][`IPF_DIAG_OVR_BIT], 1'b1);
        check("overrun cleared", diagnostic_status[`IPF_DIAG_OVR_BIT], 1'b0);
        $display("test budget dec %0d done", dec);
    endtask

    task automatic datapath(input logic [15:0] dec, input logic [2:0] filt, input logic [31:0] v);
        int i;
        int g;
        logic [31:0] full;
        @(posedge clk);
        cfg <= '{dec: dec, filt: filt};
        pulse_samples(dec + 1, v);
        for (i = 0; i < 6; i++) host.txw[i] = {1'b0, `IPF_ADDR_GX_LO + 7'(2 * i), 8'h00};
        host.txw[6] = {1'b0, `IPF_ADDR_AX_HI, 8'h00};
        host.txw[7] = {1'b0, `IPF_ADDR_AY_HI, 8'h00};
        host.txw[8] = {1'b0, `IPF_ADDR_AZ_HI, 8'h00};
        rd(9);
        for (i = 0; i < 3; i++) check("accel upper", host.rxw[7 + i], 16'h0a00 + 16'(dec));
        g = $clog2(dec + 1) + 2 * filt;
        for (i = 0; i < 3; i++) begin
            full = (v + 32'(i)) * (dec + 1);
            full = (g >= 16) ? full : full << (16 - g);
            check("gyro lower", host.rxw[2 * i + 1], full[15:0]);
            check("gyro upper", host.rxw[2 * i + 2], full[31:16]);
        end
        $display("test datapath dec %0d filt %0d done", dec, filt);
    endtask

    task automatic frame_errors();
        int tries;
        host.txw[0] = CMD_PROD;
        host.txw[1] = CMD_PROD;
        host.frame(20);
        check("state after excess", port_state, ST_DESYNC);
        check("desync flag", diagnostic_status[`IPF_DIAG_DESYNC_BIT], 1'b1);
        host.recover(`IPF_PROD_CODE, tries);
        check("recovery tries", tries, 32'd1);
        check("state after recovery", port_state, ST_OK);
        // a write aimed at the read-only code must leave it unchanged
        host.txw[0] = {1'b1, `IPF_ADDR_PROD, 8'h00};
        host.txw[1] = CMD_PROD;
        rd(2);
        check("code after write", host.rxw[2], `IPF_PROD_CODE);
        host.frame(5);
        check("state after short", port_state, ST_LOCKED);
        check("lock flag", diagnostic_status[`IPF_DIAG_LOCK_BIT], 1'b1);
        host.frame(17);
        check("lock held", port_state, ST_LOCKED);
        host.txw[0] = CMD_PROD;
        rd(1);
        check("locked answer", host.rxw[1], 16'h0000);
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (6) @(posedge clk);
        check("state after reset", port_state, ST_OK);
        rd(1);
        check("code after reset", host.rxw[1], `IPF_PROD_CODE);
        $display("test frame errors done");
    endtask

    initial begin
        n_fail = 0;
        compares = 0;
        cycles = 0;
        sys_rst = 1'b1;
        sample_valid = 1'b0;
        sample = '0;
        cfg = '0;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (6) @(posedge clk);
        budget(16'h0000);
        budget(16'h0002);
        datapath(16'h0000, 3'h0, 32'h1234);
        datapath(16'h0007, 3'h2, 32'h35);
        datapath(16'h0001, 3'h1, 32'h4321);
        datapath(16'h0003, 3'h7, 32'h12345);
        frame_errors();
        report_and_stop();
    end
endmodule
`default_nettype wire
